//--- src/amc_pkg.sv
// shared constants for the mode, clock and test-pattern register block
package amc_pkg;
   localparam int NCH         = 8;
   localparam int DW          = 12;
   localparam int HDR_BITS    = 16;
   localparam int DATA_BITS   = 8;
   // register addresses on the serial control port
   localparam logic [12:0] ADDR_IDX2 = 13'h0004;
   localparam logic [12:0] ADDR_IDX1 = 13'h0005;
   localparam logic [12:0] ADDR_MODE = 13'h0008;
   localparam logic [12:0] ADDR_CLK  = 13'h0009;
   localparam logic [12:0] ADDR_TEST = 13'h000D;
   localparam logic [12:0] ADDR_XFER = 13'h00FF;
   // reset values
   localparam logic [7:0] RST_IDX  = 8'h0F;
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [7:0] RST_CLK  = 8'h01;
   localparam logic [7:0] RST_TEST = 8'h00;
   // field positions
   localparam int HDR_RW_BIT = 15;
   localparam int DCS_BIT    = 0;
   localparam int XFER_BIT   = 0;
   localparam int PNRST_BIT  = 4;
   localparam int UMODE_LSB  = 6;
   localparam int CLKD_BIT   = 5;
   localparam int CLKF_BIT   = 4;
   // operating mode codes
   localparam logic [2:0] MODE_RUN   = 3'h0;
   localparam logic [2:0] MODE_POWERED_DOWN  = 3'h1;
   localparam logic [2:0] MODE_STBY  = 3'h2;
   localparam logic [2:0] MODE_RESET = 3'h3;
   localparam logic [2:0] MODE_CWD   = 3'h4;
   // output test codes
   localparam logic [3:0] OTM_OFF   = 4'h0;
   localparam logic [3:0] OTM_MID   = 4'h1;
   localparam logic [3:0] OTM_PFS   = 4'h2;
   localparam logic [3:0] OTM_NFS   = 4'h3;
   localparam logic [3:0] OTM_CHK   = 4'h4;
   localparam logic [3:0] OTM_PNL   = 4'h5;
   localparam logic [3:0] OTM_PNS   = 4'h6;
   localparam logic [3:0] OTM_WTOG  = 4'h7;
   localparam logic [3:0] OTM_USER  = 4'h8;
   localparam logic [3:0] OTM_BTOG  = 4'h9;
   localparam logic [3:0] OTM_SYNC  = 4'hA;
   localparam logic [3:0] OTM_ONEB  = 4'hB;
   localparam logic [3:0] OTM_MIXED = 4'hC;
   // pattern words, offset binary
   localparam logic [11:0] PAT_MID   = 12'h800;
   localparam logic [11:0] PAT_PFS   = 12'hFFF;
   localparam logic [11:0] PAT_NFS   = 12'h000;
   localparam logic [11:0] PAT_CHK_A = 12'hAAA;
   localparam logic [11:0] PAT_CHK_B = 12'h555;
   localparam logic [11:0] PAT_SYNC  = 12'h03F;
   localparam logic [11:0] PAT_ONEB  = 12'h800;
   localparam logic [11:0] PAT_MIXED = 12'hA33;
   // generator seeds
   localparam logic [22:0] PNL_SEED = 23'h7FFFFF;
   localparam logic [8:0]  PNS_SEED = 9'h1FF;
   typedef enum logic [1:0] {SPI_IDLE, SPI_HDR, SPI_DATA, SPI_DONE} amc_spi_state_type;
endpackage

//--- src/amc_tpmem_if.sv
// carrier between register core and per-channel test register store
interface amc_tpmem_if;
   import amc_pkg::*;
   logic               wr_en;
   logic [NCH-1:0]     wr_mask;
   logic [7:0]         wr_data;
   logic               xfer;
   logic [2:0]         rd_ch;
   logic [7:0]         rd_data;
   logic [NCH*8-1:0]   active;
   modport core (output wr_en, wr_mask, wr_data, xfer, rd_ch, input rd_data, active);
   modport mem  (input wr_en, wr_mask, wr_data, xfer, rd_ch, output rd_data, active);
endinterface

//--- src/amc_tpmem.sv
// staged and active test register per channel
module amc_tpmem
   import amc_pkg::*;
(
   input wire logic clk,   // sample clock
   input wire logic rst_n, // sync reset, low
   amc_tpmem_if.mem m      // core side
);
   logic [7:0] stg_r   [NCH];
   logic [7:0] stg_nxt [NCH];
   logic [7:0] act_r   [NCH];
   logic [7:0] act_nxt [NCH];
   logic [7:0] rd_r;
   logic [7:0] rd_nxt;

   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         stg_nxt[i] = stg_r[i];
         act_nxt[i] = act_r[i];
         if (m.wr_en && m.wr_mask[i])
            stg_nxt[i] = m.wr_data;
         if (m.xfer)
            act_nxt[i] = stg_r[i];
      end
      rd_nxt = stg_r[m.rd_ch];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            stg_r[i] <= RST_TEST;
            act_r[i] <= RST_TEST;
         end
         rd_r <= 8'h00;
      end
      else
      begin
         stg_r <= stg_nxt;
         act_r <= act_nxt;
         rd_r  <= rd_nxt;
      end
   end

   assign m.rd_data = rd_r;
   for (genvar g = 0; g < NCH; g++)
   begin : g_act
      assign m.active[g*8 +: 8] = act_r[g];
   end

   property p_unsel_kept;
      @(posedge clk) disable iff (!rst_n)
      m.wr_en && !m.wr_mask[NCH-1] && !m.xfer |=> stg_r[NCH-1] == $past(stg_r[NCH-1]);
   endproperty
   a_unsel_kept: assert property (p_unsel_kept) else $error("unselected channel written");
endmodule

//--- src/amc_regs.sv
// mode, clock and test-pattern registers behind the serial control port
// Behaviour
// - mode 000 run, 001 power-down, 010 standby
// - mode 011 reset, 100 cw, gain path off
// - clock bit0 enables duty stabilizer, default on
// - user test mode field selects alternation style
// - generator reset bit holds short sequence generator
// - test codes 0-3: off, midscale, +full, -full
// - codes 4-6: checkerboard, long, short sequences
// - codes 7-9: word toggle, user word, bit toggle
// - test pattern replaces samples on outputs
// - test selects per channel, sequence settings global
// - patterns follow the selected output number format
// - index bits choose channels receiving local writes
// - transfer bit copies staged values to active
module amc_regs
   import amc_pkg::*;
(
   input  wire logic              clk,                     // sample clock, 250 MHz
   input  wire logic              rst_n,                   // sync reset, low
   input  wire logic              spi_sclk,                // serial port clock pin
   input  wire logic              spi_csb_n,               // serial port select, low
   input  wire logic              spi_sdio_i,              // serial data pin in
   output logic                   spi_sdio_o,              // serial data pin out
   output logic                   spi_sdio_oe,             // high while driving sdio
   input  wire logic [NCH*DW-1:0] adc_sample,              // converted samples, A in low bits
   input  wire logic              adc_valid,               // one pulse per sample
   input  wire logic              fmt_twos_cmp,            // output format: twos complement
   input  wire logic [DW-1:0]     user_pattern,            // user pattern word
   output logic [NCH*DW-1:0]      ser_data,                // words to the serial outputs
   output logic                   ser_valid,               // ser_data updated, run and cw modes only
   output logic                   powered_down,            // full power-down
   output logic                   standby,                 // standby
   output logic                   chip_in_reset,           // held in reset
   output logic                   continuous_wave_doppler, // cw mode
   output logic                   time_gain_path_on,       // gain path powered
   output logic                   duty_stabilizer_en,      // duty cycle stabilizer on
   output logic                   dco_sel,                 // clock channel DCO addressed
   output logic                   fco_sel                  // clock channel FCO addressed
);
   amc_tpmem_if tp ();
   amc_tpmem u_mem (.clk(clk), .rst_n(rst_n), .m(tp.mem));

   // pin synchronisers; third stage only feeds edge detection
   logic [2:0] sclk_r;
   logic [1:0] csb_r;
   logic [1:0] sdio_r;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sclk_r <= 3'h0;
         csb_r  <= 2'h3;
         sdio_r <= 2'h0;
      end
      else
      begin
         sclk_r <= {sclk_r[1:0], spi_sclk};
         csb_r  <= {csb_r[0], spi_csb_n};
         sdio_r <= {sdio_r[0], spi_sdio_i};
      end
   end
   logic sclk_rise;
   logic sclk_fall;
   assign sclk_rise = sclk_r[1] & ~sclk_r[2];
   assign sclk_fall = ~sclk_r[1] & sclk_r[2];

   // registers
   logic [7:0] idx1_r, idx1_nxt, idx2_r, idx2_nxt;
   logic [2:0] mode_stg_r, mode_stg_nxt, mode_r, mode_nxt;
   logic       dcs_stg_r, dcs_stg_nxt, dcs_r, dcs_nxt;
   logic       pn_stg_r, pn_stg_nxt, pn_r, pn_nxt;
   // serial port engine
   amc_spi_state_type st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [15:0] hdr_r, hdr_nxt;
   logic [7:0]  dat_r, dat_nxt;
   logic [7:0]  sdo_r, sdo_nxt;
   logic        oe_r, oe_nxt;
   logic        wr_go;
   logic        xfer_go;
   logic [12:0] rd_addr;
   logic [NCH-1:0] ch_mask;

   assign ch_mask = {idx2_r[3:0], idx1_r[3:0]};

   function automatic logic [2:0] first_ch(input logic [NCH-1:0] mask);
      logic [2:0] c;
      c = 3'h0;
      for (int i = NCH - 1; i >= 0; i--)
         if (mask[i])
            c = 3'(i);
      return c;
   endfunction

   function automatic logic [7:0] reg_read(input logic [12:0] a);
      case (a)
         ADDR_IDX1: return idx1_r;
         ADDR_IDX2: return idx2_r;
         ADDR_MODE: return {5'h00, mode_stg_r};
         ADDR_CLK:  return {7'h00, dcs_stg_r};
         ADDR_TEST: return tp.rd_data;
         default:   return 8'h00;
      endcase
   endfunction

   assign rd_addr = {hdr_r[11:0], sdio_r[1]};

   always_comb
   begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      hdr_nxt = hdr_r;
      dat_nxt = dat_r;
      sdo_nxt = sdo_r;
      oe_nxt  = oe_r;
      wr_go   = 1'b0;
      if (csb_r[1])
      begin
         st_nxt = SPI_IDLE;
         oe_nxt = 1'b0;
      end
      else
         case (st_r)
            SPI_IDLE:
            begin
               st_nxt  = SPI_HDR;
               cnt_nxt = 4'h0;
            end
            SPI_HDR:
               if (sclk_rise)
               begin
                  hdr_nxt = {hdr_r[14:0], sdio_r[1]};
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == 4'(HDR_BITS - 1))
                  begin
                     st_nxt  = SPI_DATA;
                     cnt_nxt = 4'h0;
                     sdo_nxt = reg_read(rd_addr);
                     oe_nxt  = hdr_r[HDR_RW_BIT-1];
                  end
               end
            SPI_DATA:
               if (sclk_rise)
               begin
                  dat_nxt = {dat_r[6:0], sdio_r[1]};
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == 4'(DATA_BITS - 1))
                  begin
                     st_nxt = SPI_DONE;
                     wr_go  = ~hdr_r[HDR_RW_BIT];
                  end
               end
               else if (sclk_fall && cnt_r != 4'h0)
                  sdo_nxt = {sdo_r[6:0], 1'b0};
            SPI_DONE:
               if (sclk_fall)
                  oe_nxt = 1'b0;
            default:
               st_nxt = SPI_IDLE;
         endcase
   end

   logic [7:0] wdat;
   assign wdat    = {dat_r[6:0], sdio_r[1]};
   assign xfer_go = wr_go && hdr_r[12:0] == ADDR_XFER && wdat[XFER_BIT];
   assign tp.wr_en   = wr_go && hdr_r[12:0] == ADDR_TEST;
   assign tp.wr_mask = ch_mask;
   assign tp.wr_data = wdat;
   assign tp.xfer    = xfer_go;
   assign tp.rd_ch   = first_ch(ch_mask);

   always_comb
   begin
      idx1_nxt     = idx1_r;
      idx2_nxt     = idx2_r;
      mode_stg_nxt = mode_stg_r;
      dcs_stg_nxt  = dcs_stg_r;
      pn_stg_nxt   = pn_stg_r;
      if (wr_go)
         case (hdr_r[12:0])
            ADDR_IDX1: idx1_nxt = {2'h0, wdat[5:0]};
            ADDR_IDX2: idx2_nxt = {4'h0, wdat[3:0]};
            ADDR_MODE: mode_stg_nxt = wdat[2:0];
            ADDR_CLK:  dcs_stg_nxt = wdat[DCS_BIT];
            ADDR_TEST: pn_stg_nxt = wdat[PNRST_BIT];
            default:   ;
         endcase
      // staged values only reach the block on a transfer
      mode_nxt = xfer_go ? mode_stg_r : mode_r;
      dcs_nxt  = xfer_go ? dcs_stg_r : dcs_r;
      pn_nxt   = xfer_go ? pn_stg_r : pn_r;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r       <= SPI_IDLE;
         cnt_r      <= 4'h0;
         hdr_r      <= 16'h0000;
         dat_r      <= 8'h00;
         sdo_r      <= 8'h00;
         oe_r       <= 1'b0;
         idx1_r     <= RST_IDX;
         idx2_r     <= RST_IDX;
         mode_stg_r <= RST_MODE;
         mode_r     <= RST_MODE;
         dcs_stg_r  <= RST_CLK[DCS_BIT];
         dcs_r      <= RST_CLK[DCS_BIT];
         pn_stg_r   <= RST_TEST[PNRST_BIT];
         pn_r       <= RST_TEST[PNRST_BIT];
      end
      else
      begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         hdr_r      <= hdr_nxt;
         dat_r      <= dat_nxt;
         sdo_r      <= sdo_nxt;
         oe_r       <= oe_nxt;
         idx1_r     <= idx1_nxt;
         idx2_r     <= idx2_nxt;
         mode_stg_r <= mode_stg_nxt;
         mode_r     <= mode_nxt;
         dcs_stg_r  <= dcs_stg_nxt;
         dcs_r      <= dcs_nxt;
         pn_stg_r   <= pn_stg_nxt;
         pn_r       <= pn_nxt;
      end
   end

   assign spi_sdio_o  = sdo_r[7];
   assign spi_sdio_oe = oe_r;
   assign powered_down            = mode_r == MODE_POWERED_DOWN;
   assign standby                 = mode_r == MODE_STBY;
   assign chip_in_reset           = mode_r == MODE_RESET;
   assign continuous_wave_doppler = mode_r == MODE_CWD;
   assign time_gain_path_on       = mode_r == MODE_RUN;
   assign duty_stabilizer_en      = dcs_r;
   assign dco_sel = idx1_r[CLKD_BIT];
   assign fco_sel = idx1_r[CLKF_BIT];

   // shared generators: one long and one short sequence for all channels
   logic [22:0] pnl_r, pnl_nxt;
   logic [8:0]  pns_r, pns_nxt;
   logic        ph_r, ph_nxt;
   logic [NCH*DW-1:0] out_r, out_nxt;
   logic        vld_r, vld_nxt;

   function automatic logic [DW-1:0] pattern(input logic [7:0] t, input logic [DW-1:0] usr,
                                              input logic ph, input logic [DW-1:0] pl,
                                              input logic [DW-1:0] ps, input logic twos);
      logic [DW-1:0] w;
      case (t[3:0])
         OTM_MID:   w = PAT_MID;
         OTM_PFS:   w = PAT_PFS;
         OTM_NFS:   w = PAT_NFS;
         OTM_CHK:   w = ph ? PAT_CHK_B : PAT_CHK_A;
         OTM_PNL:   w = pl;
         OTM_PNS:   w = ps;
         OTM_WTOG:  w = ph ? PAT_NFS : PAT_PFS;
         OTM_USER:  w = (t[UMODE_LSB] && ph) ? ~usr : usr;
         OTM_BTOG:  w = PAT_CHK_A;
         OTM_SYNC:  w = PAT_SYNC;
         OTM_ONEB:  w = PAT_ONEB;
         OTM_MIXED: w = PAT_MIXED;
         default:   w = PAT_MID;
      endcase
      // patterns are built offset binary; flipping the top bit gives twos complement
      return twos ? {~w[DW-1], w[DW-2:0]} : w;
   endfunction

   always_comb
   begin
      pnl_nxt = pnl_r;
      pns_nxt = pns_r;
      ph_nxt  = ph_r;
      if (adc_valid)
      begin
         pnl_nxt = {pnl_r[21:0], pnl_r[22] ^ pnl_r[17]};
         pns_nxt = {pns_r[7:0], pns_r[8] ^ pns_r[4]};
         ph_nxt  = ~ph_r;
      end
      if (chip_in_reset)
      begin
         pnl_nxt = PNL_SEED;
         ph_nxt  = 1'b0;
      end
      if (chip_in_reset || pn_r)
         pns_nxt = PNS_SEED;
      vld_nxt = adc_valid && (time_gain_path_on || continuous_wave_doppler);
      out_nxt = out_r;
      for (int i = 0; i < NCH; i++)
         if (adc_valid)
            out_nxt[i*DW +: DW] = (tp.active[i*8 +: 4] == OTM_OFF) ? adc_sample[i*DW +: DW] :
               pattern(tp.active[i*8 +: 8], user_pattern, ph_r, pnl_r[DW-1:0],
                       {3'h0, pns_r}, fmt_twos_cmp);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pnl_r <= PNL_SEED;
         pns_r <= PNS_SEED;
         ph_r  <= 1'b0;
         out_r <= '0;
         vld_r <= 1'b0;
      end
      else
      begin
         pnl_r <= pnl_nxt;
         pns_r <= pns_nxt;
         ph_r  <= ph_nxt;
         out_r <= out_nxt;
         vld_r <= vld_nxt;
      end
   end
   assign ser_data  = out_r;
   assign ser_valid = vld_r;

   property p_powered_down_on_xfer;
      @(posedge clk) disable iff (!rst_n)
      xfer_go && mode_stg_r == MODE_POWERED_DOWN |=> powered_down && !standby;
   endproperty
   a_powered_down_on_xfer: assert property (p_powered_down_on_xfer) else $error("power-down not applied");
   property p_cw_no_gain;
      @(posedge clk) disable iff (!rst_n)
      xfer_go && mode_stg_r == MODE_CWD |=> continuous_wave_doppler && !time_gain_path_on;
   endproperty
   a_cw_no_gain: assert property (p_cw_no_gain) else $error("cw mode left gain path on");
   property p_reset_holds_gen;
      @(posedge clk) disable iff (!rst_n)
      chip_in_reset |=> pnl_r == PNL_SEED;
   endproperty
   a_reset_holds_gen: assert property (p_reset_holds_gen) else $error("generator ran in reset");
   property p_dcs;
      @(posedge clk) disable iff (!rst_n)
      xfer_go |=> duty_stabilizer_en == $past(dcs_stg_r);
   endproperty
   a_dcs: assert property (p_dcs) else $error("stabilizer setting not applied");
   property p_pns_held;
      @(posedge clk) disable iff (!rst_n)
      pn_r ##1 pn_r |-> pns_r == PNS_SEED;
   endproperty
   a_pns_held: assert property (p_pns_held) else $error("short generator not held");
   property p_mid;
      @(posedge clk) disable iff (!rst_n)
      adc_valid && tp.active[3:0] == OTM_MID && !fmt_twos_cmp |=> ser_data[DW-1:0] == PAT_MID;
   endproperty
   a_mid: assert property (p_mid) else $error("midscale word wrong");
   property p_pass;
      @(posedge clk) disable iff (!rst_n)
      adc_valid && tp.active[3:0] == OTM_OFF |=> ser_data[DW-1:0] == $past(adc_sample[DW-1:0]);
   endproperty
   a_pass: assert property (p_pass) else $error("sample not passed through");
   property p_twos;
      @(posedge clk) disable iff (!rst_n)
      adc_valid && tp.active[3:0] == OTM_PFS && fmt_twos_cmp |=> ser_data[DW-1:0] == 12'h7FF;
   endproperty
   a_twos: assert property (p_twos) else $error("format not applied");
   property p_stage_only;
      @(posedge clk) disable iff (!rst_n)
      !xfer_go |=> mode_r == $past(mode_r) && dcs_r == $past(dcs_r);
   endproperty
   a_stage_only: assert property (p_stage_only) else $error("active changed without transfer");
endmodule

//--- verification/amc_host.sv
// host model that drives the serial control port
module amc_host
(
   input  wire logic clk,    // paces the serial clock
   input  wire logic sdio,   // resolved data line
   output logic      sclk,   // idles low outside frames
   output logic      csb_n,  // select, low
   output logic      sdio_d, // host data bit
   output logic      sdio_en // high while host drives
);
   timeunit 1ns;
   timeprecision 1ps;
   // six clk per half period keeps margin over the three the port needs
   localparam int HALF = 6;
   initial
   begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio_d = 1'b0;
      sdio_en = 1'b0;
   end
   task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] din,
                        output logic [7:0] dout);
      logic [23:0] sh;
      sh = {rd, 2'b00, a, din};
      dout = 8'h00;
      @(negedge clk);
      csb_n = 1'b0;
      sdio_en = 1'b1;
      for (int i = 23; i >= 0; i--)
      begin
         sdio_d = sh[i];
         repeat (HALF) @(negedge clk);
         sclk = 1'b1;
         if (rd && i < 8)
            dout[i] = sdio;
         repeat (HALF) @(negedge clk);
         sclk = 1'b0;
         // hold the last address bit through its high half: the port samples it clocks late
         if (rd && i == 8)
            sdio_en = 1'b0;
      end
      sdio_en = 1'b0;
      repeat (HALF) @(negedge clk);
      csb_n = 1'b1;
      repeat (HALF) @(negedge clk);
   endtask
   task automatic xfer;
      logic [7:0] unused;
      frame(1'b0, 13'h00FF, 8'h01, unused);
   endtask
endmodule

//--- verification/amc_regs_test.sv
// self-checking bench for the mode, clock and test-pattern registers
`define CHK(n, e, g) \
begin \
   check_count++; \
   if ((g) !== (e)) \
   begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", n, e, g); \
   end \
end
module amc_regs_test
   import amc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst_n, sclk, csb_n, hd, hen, sdio_o, sdio_oe, sv;
   logic              adc_valid, fmt, ser_valid, pd, sb, cir, cwd, tgp, dse, dco, fco;
   logic [NCH*DW-1:0] adc_sample, ser_data, sd;
   logic [DW-1:0]     user_pat, a;
   logic [7:0]        rv;
   logic [4:0]        ex;
   int                fail_count = 0;
   int                check_count = 0;
   // the last entry is an unassigned code, which falls back to midscale
   logic [3:0]        codes [8] = '{OTM_MID, OTM_PFS, OTM_NFS, OTM_BTOG, OTM_SYNC,
                                    OTM_ONEB, OTM_MIXED, 4'hD};
   logic [11:0]       pats [8] = '{PAT_MID, PAT_PFS, PAT_NFS, 12'hAAA, PAT_SYNC,
                                   PAT_ONEB, PAT_MIXED, PAT_MID};
   logic [11:0]       tw [2] = '{12'hAAA, 12'hFFF};
   // a released line shows the inverse of the last host bit, never a held value
   wire               sdio_w = sdio_oe ? sdio_o : (hen ? hd : ~hd);

   amc_host host (.clk(clk), .sdio(sdio_w), .sclk(sclk), .csb_n(csb_n), .sdio_d(hd),
                  .sdio_en(hen));
   amc_regs dut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_csb_n(csb_n),
      .spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe),
      .adc_sample(adc_sample), .adc_valid(adc_valid), .fmt_twos_cmp(fmt),
      .user_pattern(user_pat), .ser_data(ser_data), .ser_valid(ser_valid),
      .powered_down(pd), .standby(sb), .chip_in_reset(cir),
      .continuous_wave_doppler(cwd), .time_gain_path_on(tgp),
      .duty_stabilizer_en(dse), .dco_sel(dco), .fco_sel(fco));

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [12:0] ad, input logic [7:0] d);
      host.frame(1'b0, ad, d, rv);
   endtask
   task automatic rchk(input logic [12:0] ad, input logic [7:0] e);
      host.frame(1'b1, ad, 8'h00, rv);
      `CHK("readback", e, rv)
   endtask
   task automatic tp(input logic [7:0] d);
      wr(ADDR_TEST, d);
      host.xfer();
   endtask
   task automatic smp;
      @(negedge clk);
      adc_valid = 1'b1;
      @(negedge clk);
      adc_valid = 1'b0;
      sd = ser_data;
      sv = ser_valid;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      fail_count++;
      final_report();
   end
   initial
   begin
      rst_n = 1'b0;
      adc_valid = 1'b0;
      fmt = 1'b0;
      user_pat = 12'h5A3;
      adc_sample = 96'h123_456_789_ABC_DEF_135_246_357;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("reset_outs", 4'b1100, {tgp, dse, dco, fco})
      rchk(ADDR_MODE, 8'h00);
      rchk(ADDR_CLK, 8'h01);
      rchk(ADDR_TEST, 8'h00);
      rchk(ADDR_IDX1, 8'h0F);
      rchk(ADDR_IDX2, 8'h0F);
      rchk(ADDR_XFER, 8'h00);
      wr(13'h0020, 8'hFF);
      rchk(13'h0020, 8'h00);
      for (int m = 0; m < 6; m++)
      begin
         wr(ADDR_MODE, 8'hF8 | 8'(m));
         rchk(ADDR_MODE, 8'(m));
         `CHK("staged_mode", 1'(m == 2), pd)
         host.xfer();
         smp();
         ex = {1'(m == 1), 1'(m == 2), 1'(m == 3), 1'(m == 4), 1'(m == 0)};
         `CHK("mode_outs", ex, {pd, sb, cir, cwd, tgp})
         `CHK("mode_valid", 1'(m == 0 || m == 4), sv)
      end
      wr(ADDR_MODE, 8'h00);
      host.xfer();
      wr(ADDR_CLK, 8'h00);
      `CHK("dse_staged", 1'b1, dse)
      host.xfer();
      `CHK("dse_off", 1'b0, dse)
      wr(ADDR_CLK, 8'hFF);
      host.xfer();
      `CHK("dse_on", 1'b1, dse)
      rchk(ADDR_CLK, 8'h01);
      for (int f = 0; f < 2; f++)
      begin
         fmt = f[0];
         for (int i = 0; i < 8; i++)
         begin
            tp({4'h0, codes[i]});
            smp();
            a = pats[i] ^ {f[0], 11'h000};
            `CHK("chan_a", a, sd[11:0])
            `CHK("chan_h", a, sd[95:84])
         end
      end
      fmt = 1'b0;
      for (int u = 0; u < 4; u++)
      begin
         tp({u[1:0], 2'b00, OTM_USER});
         smp();
         a = sd[11:0];
         `CHK("user_word", 1'b1, 1'(a == user_pat || a == ~user_pat))
         smp();
         `CHK("user_alt", u[0] ? ~a : a, sd[11:0])
      end
      for (int i = 0; i < 2; i++)
      begin
         tp({4'h0, i ? OTM_WTOG : OTM_CHK});
         smp();
         a = sd[11:0];
         `CHK("tog_word", 1'b1, 1'(a == tw[i] || a == ~tw[i]))
         smp();
         `CHK("tog_alt", ~a, sd[11:0])
         tp({4'h0, i ? OTM_PNL : OTM_PNS});
         smp();
         a = sd[11:0];
         smp();
         `CHK("seq_runs", 1'b1, 1'(a != sd[11:0]))
      end
      tp(8'h10 | {4'h0, OTM_PNS});
      smp();
      smp();
      `CHK("seq_held", 12'(PNS_SEED), sd[11:0])
      tp(8'h00);
      smp();
      `CHK("pass", adc_sample, sd)
      tp({4'h0, OTM_PNS});
      wr(ADDR_IDX2, 8'h00);
      wr(ADDR_IDX1, 8'h01);
      tp(8'h10 | {4'h0, OTM_PFS});
      smp();
      smp();
      `CHK("seq_global", 12'(PNS_SEED), sd[95:84])
      `CHK("chan_a_only", PAT_PFS, sd[11:0])
      tp({4'h0, OTM_MID});
      smp();
      `CHK("chan_b_kept", 12'(PNS_SEED), sd[23:12])
      rchk(ADDR_TEST, {4'h0, OTM_MID});
      wr(ADDR_IDX1, 8'h3F);
      `CHK("dco_fco", 2'b11, {dco, fco})
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK("rerun_outs", 4'b1100, {tgp, dse, dco, fco})
      final_report();
   end
endmodule
